// ---- verilog/rtc_dev_end.sv ----
// clock device end: calendar, interrupt pin formats, supply sampler
//
// The address map and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/10ps
module rtc_dev_end #(
   parameter int TICK_CYC_P = rtc_pkg::TICK_CYC
) (
   input  wire logic  aclk,
   input  wire logic  aresetn,
   rtc_link_if.dev    link,
   input  wire logic  supply_low,
   output      logic  sampler_on
);
   import rtc_pkg::*;

   // ***************************************************************
   // helpers
   // ***************************************************************
   function automatic logic [4:0] rtc_dim(input logic [3:0] m,
                                          input logic [6:0] y);
      logic [4:0] d;
      d = 5'h1F;
      if (m == 4'h2)
         d = (y[1:0] == 2'h0) ? 5'h1D : 5'h1C;
      else if (m == 4'h4 || m == 4'h6 || m == 4'h9 || m == 4'hB)
         d = 5'h1E;
      return d;
   endfunction : rtc_dim

   function automatic rtc_mode_e rtc_mode(input logic ae,
                                          input logic me,
                                          input logic fe);
      rtc_mode_e md;
      if (me || fe)
         md = rtc_mode_e'({1'b0, me, fe});
      else
         md = ae ? MD_ALARM : MD_OFF;
      return md;
   endfunction : rtc_mode

   // ***************************************************************
   // state
   // ***************************************************************
   logic [10:0] pre_reg;
   logic [15:0] div_reg;
   logic [5:0]  sec_reg,  sec_next;
   logic [5:0]  min_reg,  min_next;
   logic [4:0]  hour_reg, hour_next;
   logic [4:0]  day_reg,  day_next;
   logic [3:0]  mon_reg,  mon_next;
   logic [6:0]  year_reg, year_next;
   logic        h24_reg, ae_reg, me_reg, fe_reg;
   logic        det_reg, halt_reg, test_reg;
   logic [15:0] intr_reg;
   logic        held_reg, arm_reg, sq_reg, oe_reg, samp_reg;
   logic        sup_m_reg, sup_s_reg;
   logic        rv_reg;
   logic [31:0] rd_reg;

   // ***************************************************************
   // decode
   // ***************************************************************
   wire        fire    = link.cmd_valid;
   wire        op_rst  = fire && link.cmd_op == OP_RESET;
   wire        op_swr  = fire && link.cmd_op == OP_ST_WR;
   wire        op_srd  = fire && link.cmd_op == OP_ST_RD;
   wire        op_awr  = fire && link.cmd_op == OP_AL_WR;
   wire        op_twr  = fire && link.cmd_op == OP_TM_WR;
   wire        op_trd  = fire && link.cmd_op == OP_TM_RD;
   wire        op_te   = fire && link.cmd_op == OP_TEST_E;
   wire        op_ts   = fire && link.cmd_op == OP_TEST_S;
   wire        tick    = pre_reg == 11'(TICK_CYC_P - 1);
   wire        sec_tick  = tick && div_reg == 16'hFFFF;
   wire        min_carry = sec_tick && sec_reg == 6'h3B;
   wire        win     = div_reg < 16'(WIN_TICKS);
   wire        drop    = samp_reg && sup_s_reg;
   rtc_mode_e  mode;
   assign mode = rtc_mode(ae_reg, me_reg, fe_reg);
   wire        al_hit  = mode == MD_ALARM
                      && hour_reg == intr_reg[AL_HOUR_LSB +: 5]
                      && min_reg == intr_reg[AL_MIN_LSB +: 6];
   wire        ed_hit  = mode == MD_EDGE && arm_reg && min_carry;
   // a hit caught in the clearing write survives into a later mode only if that mode is alarm or edge
   wire        hold_ok = mode == MD_ALARM || mode == MD_EDGE;
   // each selected clock must be high; unselected bits force one
   wire        f_lvl   = &(div_reg | ~intr_reg);
   wire        sq_low  = sq_reg && sec_reg < 6'h1E;
   logic       assert_int;

   always_comb
   begin
      unique case (mode)
         MD_OFF:   assert_int = 1'b0;
         MD_ALARM: assert_int = held_reg;
         MD_FREQ:  assert_int = !f_lvl;
         MD_EDGE:  assert_int = held_reg;
         MD_SQ:    assert_int = sq_low;
         default:  assert_int = 1'b0;
      endcase
   end

   // ***************************************************************
   // calendar
   // ***************************************************************
   always_comb
   begin
      sec_next  = sec_reg;
      min_next  = min_reg;
      hour_next = hour_reg;
      day_next  = day_reg;
      mon_next  = mon_reg;
      year_next = year_reg;
      if (op_rst)
      begin
         sec_next  = 6'h00;
         min_next  = 6'h00;
         hour_next = 5'h00;
         day_next  = DAY_RST;
         mon_next  = MON_RST;
         year_next = YEAR_RST;
      end
      else if (op_twr)
      begin
         sec_next  = 6'h00;
         min_next  = link.cmd_data[TD_MIN_LSB +: 6];
         hour_next = link.cmd_data[TD_HOUR_LSB +: 5];
         day_next  = link.cmd_data[TD_DAY_LSB +: 5];
         mon_next  = link.cmd_data[TD_MON_LSB +: 4];
         year_next = link.cmd_data[TD_YEAR_LSB +: 7];
      end
      else if (sec_tick)
      begin
         sec_next = (sec_reg == 6'h3B) ? 6'h00 : sec_reg + 6'h01;
         if (min_carry)
         begin
            min_next = (min_reg == 6'h3B) ? 6'h00 : min_reg + 6'h01;
            if (min_reg == 6'h3B)
            begin
               hour_next = (hour_reg == 5'h17) ? 5'h00 : hour_reg + 5'h01;
               if (hour_reg == 5'h17)
                  day_next = day_reg + 5'h01;
            end
         end
      end
      // a stale day past month end rolls forward at once
      if (day_next > rtc_dim(mon_next, year_next))
      begin
         day_next = 5'h01;
         if (mon_next >= 4'hC)
         begin
            mon_next  = 4'h1;
            year_next = (year_next == 7'h63) ? 7'h00 : year_next + 7'h01;
         end
         else
            mon_next = mon_next + 4'h1;
      end
      else if (day_next == 5'h00)
         day_next = 5'h01;
   end

   // ***************************************************************
   // response word
   // ***************************************************************
   logic [31:0] st_word, tm_word;
   always_comb
   begin
      st_word         = 32'h0000_0000;
      st_word[ST_PWR] = det_reg;
      st_word[ST_H24] = h24_reg;
      st_word[ST_AE]  = ae_reg;
      st_word[ST_ME]  = me_reg;
      st_word[ST_FE]  = fe_reg;
      tm_word                      = 32'h0000_0000;
      tm_word[TD_MIN_LSB +: 6]     = min_reg;
      tm_word[TD_HOUR_LSB +: 5]    = hour_reg;
      tm_word[TD_DAY_LSB +: 5]     = day_reg;
      tm_word[TD_MON_LSB +: 4]     = mon_reg;
      tm_word[TD_YEAR_LSB +: 7]    = year_reg;
      tm_word[TD_TEST]             = test_reg;
   end

   // ***************************************************************
   // registers
   // ***************************************************************
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pre_reg <= 11'h000;
         div_reg <= 16'h0000;
      end
      else
      begin
         pre_reg <= tick ? 11'h000 : pre_reg + 11'h001;
         if (tick)
            div_reg <= div_reg + 16'h0001;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sec_reg  <= 6'h00;
         min_reg  <= 6'h00;
         hour_reg <= 5'h00;
         day_reg  <= DAY_RST;
         mon_reg  <= MON_RST;
         year_reg <= YEAR_RST;
      end
      else
      begin
         sec_reg  <= sec_next;
         min_reg  <= min_next;
         hour_reg <= hour_next;
         day_reg  <= day_next;
         mon_reg  <= mon_next;
         year_reg <= year_next;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         h24_reg  <= STATUS_POR[ST_H24];
         ae_reg   <= STATUS_POR[ST_AE];
         me_reg   <= STATUS_POR[ST_ME];
         fe_reg   <= STATUS_POR[ST_FE];
         intr_reg <= INTREG_POR;
         test_reg <= 1'b0;
      end
      else if (op_rst)
      begin
         h24_reg  <= STATUS_RST[ST_H24];
         ae_reg   <= STATUS_RST[ST_AE];
         me_reg   <= STATUS_RST[ST_ME];
         fe_reg   <= STATUS_RST[ST_FE];
         intr_reg <= INTREG_RST;
         test_reg <= 1'b0;
      end
      else
      begin
         if (op_swr)
         begin
            h24_reg <= link.cmd_data[ST_H24];
            ae_reg  <= link.cmd_data[ST_AE];
            me_reg  <= link.cmd_data[ST_ME];
            fe_reg  <= link.cmd_data[ST_FE];
         end
         if (op_awr)
            intr_reg <= link.cmd_data[15:0];
         if (op_ts)
            test_reg <= 1'b1;
         else if (op_te)
            test_reg <= 1'b0;
      end
   end

   // interrupt holding; a hit in the clearing cycle still sets the hold
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         held_reg <= 1'b0;
         arm_reg  <= 1'b0;
         sq_reg   <= 1'b0;
         oe_reg   <= 1'b0;
      end
      else
      begin
         held_reg <= al_hit || ed_hit
                  || (held_reg && hold_ok
                      && !op_swr && !op_rst);
         arm_reg  <= op_swr || (arm_reg && !min_carry);
         sq_reg   <= !op_swr && !op_rst
                  && (sq_reg || (arm_reg && min_carry));
         oe_reg   <= assert_int;
      end
   end

   // sampler; the drop wins over a read in the same cycle
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sup_m_reg <= 1'b0;
         sup_s_reg <= 1'b0;
         samp_reg  <= 1'b0;
         det_reg   <= STATUS_POR[ST_PWR];
         halt_reg  <= 1'b1;
      end
      else
      begin
         sup_m_reg <= supply_low;
         sup_s_reg <= sup_m_reg;
         samp_reg  <= win && !halt_reg && !drop;
         det_reg   <= drop || (det_reg && !op_srd && !op_rst);
         halt_reg  <= drop || (halt_reg && !op_srd && !op_rst);
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rv_reg <= 1'b0;
         rd_reg <= 32'h0000_0000;
      end
      else
      begin
         rv_reg <= op_srd || op_trd;
         if (op_srd)
            rd_reg <= st_word;
         else if (op_trd)
            rd_reg <= tm_word;
      end
   end

   assign link.cmd_ready = 1'b1;
   assign link.rsp_valid = rv_reg;
   assign link.rsp_data  = rd_reg;
   assign link.int_o     = 1'b0;
   assign link.int_oe    = oe_reg;
   assign sampler_on     = samp_reg;
endmodule : rtc_dev_end

// ---- verilog/rtc_pkg.sv ----
// shared constants, command codes and mode codes of the rtc link
package rtc_pkg;
   // ***************************************************************
   // timing
   // ***************************************************************
   localparam int CLK_HZ    = 100_000_000;
   localparam int TICK_HZ   = 65536;
   localparam int TICK_CYC  = CLK_HZ / TICK_HZ;
   localparam int WIN_US    = 15600;
   localparam int WIN_TICKS = WIN_US * TICK_HZ / 1_000_000;
   // ***************************************************************
   // status byte fields and reset values
   // ***************************************************************
   localparam int ST_PWR = 7;
   localparam int ST_H24 = 6;
   localparam int ST_AE  = 5;
   localparam int ST_ME  = 3;
   localparam int ST_FE  = 1;
   localparam logic [7:0]  STATUS_POR = 8'h82;
   localparam logic [7:0]  STATUS_RST = 8'h00;
   localparam logic [15:0] INTREG_POR = 16'h8000;
   localparam logic [15:0] INTREG_RST = 16'h0000;
   // ***************************************************************
   // time word and alarm word fields
   // ***************************************************************
   localparam int TD_MIN_LSB  = 0;
   localparam int TD_HOUR_LSB = 8;
   localparam int TD_DAY_LSB  = 16;
   localparam int TD_MON_LSB  = 21;
   localparam int TD_YEAR_LSB = 25;
   localparam int TD_TEST     = 31;
   localparam int AL_MIN_LSB  = 0;
   localparam int AL_HOUR_LSB = 8;
   localparam logic [4:0] DAY_RST  = 5'h01;
   localparam logic [3:0] MON_RST  = 4'h1;
   localparam logic [6:0] YEAR_RST = 7'h00;
   // ***************************************************************
   // host register offsets
   // ***************************************************************
   localparam logic [3:0] ADDR_CMD    = 4'h0;
   localparam logic [3:0] ADDR_DATA   = 4'h4;
   localparam logic [3:0] ADDR_RESULT = 4'h8;
   localparam logic [3:0] ADDR_STAT   = 4'hC;
   localparam int HS_BUSY = 0;
   localparam int HS_INIT = 1;
   localparam int HS_IRQ  = 2;
   // ***************************************************************
   // enumerations
   // ***************************************************************
   typedef enum logic [2:0] {
      OP_RESET  = 3'h0, OP_ST_WR  = 3'h1, OP_ST_RD = 3'h2,
      OP_AL_WR  = 3'h3, OP_TM_WR  = 3'h4, OP_TM_RD = 3'h5,
      OP_TEST_E = 3'h6, OP_TEST_S = 3'h7
   } rtc_op_e;
   typedef enum logic [2:0] {
      MD_OFF = 3'h0, MD_FREQ = 3'h1, MD_EDGE = 3'h2,
      MD_SQ  = 3'h3, MD_ALARM = 3'h4
   } rtc_mode_e;
endpackage : rtc_pkg

// ---- verilog/rtc_link_if.sv ----
// link between the clock device end and the host end
`timescale 1ns/10ps
interface rtc_link_if;
   import rtc_pkg::*;
   logic          cmd_valid;
   logic          cmd_ready;
   rtc_op_e       cmd_op;
   logic [31:0]   cmd_data;
   logic          rsp_valid;
   logic [31:0]   rsp_data;
   logic          int_o;
   logic          int_oe;
   logic          int_n;
   // open-drain pin with pull-up
   assign int_n = (int_oe && !int_o) ? 1'b0 : 1'b1;
   modport dev  (input  cmd_valid, cmd_op, cmd_data,
                 output cmd_ready, rsp_valid, rsp_data, int_o, int_oe);
   modport host (output cmd_valid, cmd_op, cmd_data,
                 input  cmd_ready, rsp_valid, rsp_data, int_n);
endinterface : rtc_link_if

// ---- verilog/rtc_host_end.sv ----
// host end: power-on initialisation and an axi4-lite command port
`timescale 1ns/10ps
module rtc_host_end (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   rtc_link_if.host          link,
   input  wire logic [3:0]   s_axi_awaddr,
   input  wire logic         s_axi_awvalid,
   output      logic         s_axi_awready,
   input  wire logic [31:0]  s_axi_wdata,
   input  wire logic [3:0]   s_axi_wstrb,
   input  wire logic         s_axi_wvalid,
   output      logic         s_axi_wready,
   output      logic [1:0]   s_axi_bresp,
   output      logic         s_axi_bvalid,
   input  wire logic         s_axi_bready,
   input  wire logic [3:0]   s_axi_araddr,
   input  wire logic         s_axi_arvalid,
   output      logic         s_axi_arready,
   output      logic [31:0]  s_axi_rdata,
   output      logic [1:0]   s_axi_rresp,
   output      logic         s_axi_rvalid,
   input  wire logic         s_axi_rready
);
   import rtc_pkg::*;

   // ***************************************************************
   // sequencer
   // ***************************************************************
   typedef enum logic [3:0] {
      S_ST_RD = 4'h0, S_ST_WT = 4'h1, S_RST  = 4'h2, S_TM_RD = 4'h3,
      S_TM_WT = 4'h4, S_TEND  = 4'h5, S_IDLE = 4'h6, S_SW    = 4'h7,
      S_SW_WT = 4'h8
   } rtc_hst_e;

   rtc_hst_e    st_reg, st_next;
   rtc_op_e     op_reg, op_next;
   logic [31:0] data_reg, res_reg;
   logic        aw_v_reg, w_v_reg, bv_reg, rv_reg, init_reg;
   logic [3:0]  aw_a_reg;
   logic [31:0] w_d_reg, rd_reg;
   logic        int_m_reg, int_s_reg;

   wire issue  = st_reg == S_ST_RD || st_reg == S_RST || st_reg == S_TM_RD
              || st_reg == S_TEND || st_reg == S_SW;
   wire taken  = issue && link.cmd_ready;
   wire do_wr  = aw_v_reg && w_v_reg;
   wire go     = do_wr && aw_a_reg == ADDR_CMD && st_reg == S_IDLE;
   wire sw_rd  = op_reg == OP_ST_RD || op_reg == OP_TM_RD;

   always_comb
   begin
      st_next = st_reg;
      op_next = op_reg;
      unique case (st_reg)
         S_ST_RD: if (taken) st_next = S_ST_WT;
         S_ST_WT:
            if (link.rsp_valid)
            begin
               // drop flag set: reset, else backed-up clock is kept
               st_next = link.rsp_data[ST_PWR] ? S_RST : S_TM_RD;
               op_next = link.rsp_data[ST_PWR] ? OP_RESET : OP_TM_RD;
            end
         S_RST:
            if (taken)
            begin
               st_next = S_TM_RD;
               op_next = OP_TM_RD;
            end
         S_TM_RD: if (taken) st_next = S_TM_WT;
         S_TM_WT:
            if (link.rsp_valid)
            begin
               st_next = link.rsp_data[TD_TEST] ? S_TEND : S_IDLE;
               op_next = OP_TEST_E;
            end
         S_TEND: if (taken) st_next = S_IDLE;
         S_IDLE:
            if (go)
            begin
               st_next = S_SW;
               op_next = rtc_op_e'(w_d_reg[2:0]);
            end
         S_SW: if (taken) st_next = sw_rd ? S_SW_WT : S_IDLE;
         S_SW_WT: if (link.rsp_valid) st_next = S_IDLE;
         default: st_next = S_IDLE;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st_reg   <= S_ST_RD;
         op_reg   <= OP_ST_RD;
         res_reg  <= 32'h0000_0000;
         init_reg <= 1'b0;
      end
      else
      begin
         st_reg <= st_next;
         op_reg <= op_next;
         if (link.rsp_valid)
            res_reg <= link.rsp_data;
         if (st_next == S_IDLE)
            init_reg <= 1'b1;
      end
   end

   assign link.cmd_valid = issue;
   assign link.cmd_op    = op_reg;
   assign link.cmd_data  = data_reg;

   // ***************************************************************
   // axi4-lite slave
   // ***************************************************************
   logic [31:0] stat_w, rsel;
   always_comb
   begin
      stat_w          = 32'h0000_0000;
      stat_w[HS_BUSY] = st_reg != S_IDLE;
      stat_w[HS_INIT] = init_reg;
      stat_w[HS_IRQ]  = !int_s_reg;
      unique case (s_axi_araddr)
         ADDR_DATA:   rsel = data_reg;
         ADDR_RESULT: rsel = res_reg;
         ADDR_STAT:   rsel = stat_w;
         default:     rsel = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_v_reg <= 1'b0;
         aw_a_reg <= 4'h0;
         w_v_reg  <= 1'b0;
         w_d_reg  <= 32'h0000_0000;
         bv_reg   <= 1'b0;
         data_reg <= 32'h0000_0000;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_v_reg <= 1'b1;
            aw_a_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_v_reg <= 1'b1;
            w_d_reg <= s_axi_wdata;
         end
         if (do_wr)
         begin
            aw_v_reg <= 1'b0;
            w_v_reg  <= 1'b0;
            bv_reg   <= 1'b1;
            if (aw_a_reg == ADDR_DATA && s_axi_wstrb != 4'h0)
               data_reg <= w_d_reg;
         end
         else if (bv_reg && s_axi_bready)
            bv_reg <= 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rv_reg    <= 1'b0;
         rd_reg    <= 32'h0000_0000;
         int_m_reg <= 1'b1;
         int_s_reg <= 1'b1;
      end
      else
      begin
         int_m_reg <= link.int_n;
         int_s_reg <= int_m_reg;
         if (s_axi_arvalid && s_axi_arready)
         begin
            rv_reg <= 1'b1;
            rd_reg <= rsel;
         end
         else if (rv_reg && s_axi_rready)
            rv_reg <= 1'b0;
      end
   end

   assign s_axi_awready = !aw_v_reg && !bv_reg;
   assign s_axi_wready  = !w_v_reg && !bv_reg;
   assign s_axi_bvalid  = bv_reg;
   assign s_axi_bresp   = 2'h0;
   assign s_axi_arready = !rv_reg;
   assign s_axi_rvalid  = rv_reg;
   assign s_axi_rdata   = rd_reg;
   assign s_axi_rresp   = 2'h0;
endmodule : rtc_host_end

// ---- dv/rtc_link_sva.sv ----
// link checker for the rtc device and host ends
`timescale 1ns/10ps
module rtc_link_sva (
   input wire logic             aclk,
   input wire logic             aresetn,
   input wire logic             cmd_valid,
   input wire rtc_pkg::rtc_op_e cmd_op,
   input wire logic [31:0]      cmd_data,
   input wire logic             rsp_valid,
   input wire logic [31:0]      rsp_data,
   input wire logic             int_n
);
   import rtc_pkg::*;
   // ********
   // properties
   // ********
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic [7:0] st_m;
   // only the writable status bits are tracked; the drop flag is not
   always_ff @(posedge aclk)
      if (!aresetn)
         st_m <= STATUS_POR & 8'h6A;
      else if (cmd_valid && cmd_op == OP_RESET)
         st_m <= STATUS_RST;
      else if (cmd_valid && cmd_op == OP_ST_WR)
         st_m <= cmd_data[7:0] & 8'h6A;
   sequence s_rsp(op);
      rsp_valid && $past(cmd_valid) && $past(cmd_op) == op;
   endsequence
   sequence s_off_wr;
      cmd_valid && cmd_op == OP_ST_WR && cmd_data[5:1] ==? 5'b0?0?0;
   endsequence
   property p_rsp_pulse; rsp_valid |-> $past(cmd_valid) &&
      $past(cmd_op) inside {OP_ST_RD, OP_TM_RD}; endproperty
   a_rsp_pulse: assert property (p_rsp_pulse) else $error("stray rsp");
   property p_rsp_hold; !rsp_valid |-> $stable(rsp_data); endproperty
   a_rsp_hold: assert property (p_rsp_hold) else $error("rsp moved");
   property p_st_echo; s_rsp(OP_ST_RD) |-> rsp_data[6:0] == st_m[6:0];
   endproperty
   a_st_echo: assert property (p_st_echo) else $error("status bits");
   property p_st_zero; s_rsp(OP_ST_RD) |-> rsp_data[31:8] == 24'h0;
   endproperty
   a_st_zero: assert property (p_st_zero) else $error("status top");
   property p_off_idle; s_off_wr |-> ##2 int_n [*3]; endproperty
   a_off_idle: assert property (p_off_idle) else $error("pin low");
   property p_rst_idle; cmd_valid && cmd_op == OP_RESET |-> ##2 int_n [*3];
   endproperty
   a_rst_idle: assert property (p_rst_idle) else $error("pin low");
   property p_por_status; $rose(aresetn) |->
      ##[0:4] (rsp_valid && rsp_data[7:0] == STATUS_POR); endproperty
   a_por_status: assert property (p_por_status) else $error("por");
   property p_day_ok; s_rsp(OP_TM_RD) |-> rsp_data[20:16] != 5'h0 &&
      !(rsp_data[24:21] == 4'h2 && rsp_data[20:16] > 5'h1D); endproperty
   a_day_ok: assert property (p_day_ok) else $error("bad day");
endmodule : rtc_link_sva

// ---- dv/rtc_interrupt_and_power_detect_bench.sv ----
// bench: both rtc ends joined, driven over the host register port
`timescale 1ns/10ps
`define CHK(g, e) if ((g) !== (e)) flag_miss(); else samples_checked++
module rtc_interrupt_and_power_detect_bench;
   import rtc_pkg::*;
   // ********
   // stimulus and checks
   // ********
   logic        aclk, aresetn, supply_low, sampler_on;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
   logic [31:0] s_axi_wdata, s_axi_rdata, r;
   int          miscompares, samples_checked;
   rtc_link_if rtc_link_if_inst ();
   rtc_dev_end #(.TICK_CYC_P(1)) rtc_dev_end_inst (.aclk, .aresetn,
      .link(rtc_link_if_inst), .supply_low, .sampler_on);
   rtc_host_end rtc_host_end_inst (.aclk, .aresetn, .link(rtc_link_if_inst),
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready);
   rtc_link_sva rtc_link_sva_inst (.aclk, .aresetn,
      .cmd_valid(rtc_link_if_inst.cmd_valid),
      .cmd_op(rtc_link_if_inst.cmd_op), .cmd_data(rtc_link_if_inst.cmd_data),
      .rsp_valid(rtc_link_if_inst.rsp_valid),
      .rsp_data(rtc_link_if_inst.rsp_data), .int_n(rtc_link_if_inst.int_n));
   task automatic flag_miss();
      samples_checked++;
      miscompares++;
      $display("FAIL %0t compare mismatch", $time);
   endtask : flag_miss
   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : stop_test
   // one idle edge first so no handshake signal is driven twice at once
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
   endtask : axi_wr
   task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      d = s_axi_rdata;
   endtask : axi_rd
   task automatic cmd(input rtc_op_e op, input logic [31:0] d,
                      output logic [31:0] q);
      axi_wr(ADDR_DATA, d);
      axi_wr(ADDR_CMD, {29'h0, op});
      do axi_rd(ADDR_STAT, q); while (q[HS_BUSY] !== 1'b0);
      axi_rd(ADDR_RESULT, q);
   endtask : cmd
   task automatic t_supply();
      wait (sampler_on === 1'b1);
      @(posedge aclk);
      supply_low <= 1'b1;
      repeat (4) @(posedge aclk);
      supply_low <= 1'b0;
      repeat (4) @(posedge aclk);
      `CHK(sampler_on, 1'b0);
      repeat (1100) @(posedge aclk);
      cmd(OP_ST_RD, 32'h0, r);
      `CHK(r[ST_PWR], 1'b1);
      cmd(OP_ST_RD, 32'h0, r);
      `CHK(r[ST_PWR], 1'b0);
   endtask : t_supply
   task automatic t_status();
      cmd(OP_ST_WR, 32'hFF, r);
      cmd(OP_ST_RD, 32'h0, r);
      `CHK(r, 32'h6A);
      axi_rd(4'h2, r);
      `CHK(r, 32'h0);
   endtask : t_status
   task automatic t_alarm();
      for (int k = 0; k < 2; k++)
      begin
         cmd(OP_AL_WR, 32'(k), r);
         cmd(OP_ST_WR, 32'h20, r);
         axi_rd(ADDR_STAT, r);
         `CHK(r[HS_IRQ], k == 0);
         `CHK(rtc_link_if_inst.int_n, k != 0);
         cmd(OP_ST_WR, 32'h0, r);
         `CHK(rtc_link_if_inst.int_n, 1'b1);
      end
   endtask : t_alarm
   task automatic t_freq();
      int lows;
      for (int k = 0; k < 3; k++)
      begin
         cmd(OP_AL_WR, 32'h7 >> (2 - k), r);
         cmd(OP_ST_WR, 32'h02, r);
         lows = 0;
         repeat (64)
         begin
            @(posedge aclk);
            lows += !rtc_link_if_inst.int_n;
         end
         `CHK(lows, 64 - (64 >> (k + 1)));
      end
   endtask : t_freq
   task automatic t_days();
      // year, month, day written, day expected; next month if day moved
      logic [31:0] tv [5] = '{32'h01021D01, 32'h04021D1D, 32'h04021E01,
                              32'h01041F01, 32'h01011F1F};
      logic [3:0]  m;
      for (int k = 0; k < 5; k++)
      begin
         m = tv[k][19:16] + 4'(tv[k][12:8] != tv[k][4:0]);
         cmd(OP_TM_WR, {tv[k][30:24], tv[k][19:16], tv[k][12:8], 16'h0}, r);
         cmd(OP_TM_RD, 32'h0, r);
         `CHK(r[24:16], {m, tv[k][4:0]});
      end
   endtask : t_days
   initial
   begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   initial
   begin
      aresetn = 1'b0;
      supply_low = 1'b0;
      s_axi_awaddr = 4'h0;
      s_axi_awvalid = 1'b0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hF;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_araddr = 4'h0;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      do axi_rd(ADDR_STAT, r); while (r[HS_INIT] !== 1'b1);
      t_supply();
      t_status();
      t_alarm();
      t_freq();
      t_days();
      stop_test();
   end
   // the longest wait is one sampler period of 65536 cycles
   initial
   begin
      repeat (98000) @(posedge aclk);
      miscompares++;
      stop_test();
   end
endmodule : rtc_interrupt_and_power_detect_bench
